/* File: design/spc_defs.svh */
/*
  Constants for the self-programming control block: register offsets,
  control bit positions, legal control patterns, windows and pointers.
  Assumes inclusion by bare name from the design file only.
*/
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define SPC_OFS_CTRL        8'h00
`define SPC_OFS_STATUS      8'h04

// ---------------------------------------------------------------
// Control register bit positions
// ---------------------------------------------------------------
`define SPC_BIT_ENABLE      0
`define SPC_BIT_PG_ERASE    1
`define SPC_BIT_PG_WRITE    2
`define SPC_BIT_FUSE_READ   3
`define SPC_BIT_CLR_BUF     4
`define SPC_BIT_SIG_READ    5

// ---------------------------------------------------------------
// Legal control patterns in the low six bits
// ---------------------------------------------------------------
`define SPC_PAT_SIG_READ    6'h21
`define SPC_PAT_CLR_BUF     6'h11
`define SPC_PAT_FUSE_READ   6'h09
`define SPC_PAT_PG_WRITE    6'h05
`define SPC_PAT_PG_ERASE    6'h03
`define SPC_PAT_STORE       6'h01

// ---------------------------------------------------------------
// Windows, pointers, reset values, bus answers
// ---------------------------------------------------------------
`define SPC_STORE_WINDOW    3'h4
`define SPC_LOAD_WINDOW     2'h3
`define SPC_PTR_FUSE_LOW    16'h0000
`define SPC_PTR_LOCK        16'h0001
`define SPC_PTR_FUSE_EXT    16'h0002
`define SPC_PTR_FUSE_HIGH   16'h0003
`define SPC_LOCK_RESET      2'h3
`define SPC_RESP_OKAY       2'h0
`define SPC_RESP_SLVERR     2'h2

`endif

/* File: design/spc_pkg.sv */
/*
  Types of the self-programming control block: sequencer states, flash
  operation codes, the core instruction carrier and the state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spc_pkg;

  typedef enum logic [2:0] {
    SPC_IDLE  = 3'h1,
    SPC_ARMED = 3'h2,
    SPC_BUSY  = 3'h4
  } spc_fsm_type;

  typedef enum logic [3:0] {
    SPC_OP_STORE = 4'h1,
    SPC_OP_ERASE = 4'h2,
    SPC_OP_WRITE = 4'h4,
    SPC_OP_CLEAR = 4'h8
  } spc_op_type;

  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] pointer;
    logic [15:0] data_word;
  } spc_core_req_type;

  typedef struct packed {
    spc_fsm_type fsm;
    logic [5:0]  ctrl;
    logic [2:0]  store_win;
    logic [1:0]  load_win;
    logic [1:0]  lock;
    logic        stall;
    logic        flash_req;
    spc_op_type  flash_op;
    logic [15:0] flash_addr;
    logic [15:0] flash_data;
    logic        load_valid;
    logic [7:0]  load_data;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_strb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } spc_state_type;

endpackage : spc_pkg

/* File: design/spc_self_program.sv */
/*
  Self-programming control: control register over AXI4-Lite, store and
  load window sequencer, flash operation requests, core stall and fuse and
  lock readback. Assumes the core presents store and load instructions as
  one-cycle strobes with pointer and data word, and the flash answers an
  erase or page write with a one-cycle done pulse.
*/
// Added by the designer: the AXI4-Lite register port and the register addresses.
// Functional notes
// - Erase select plus enable makes the next store within four cycles a page erase.
// - Page erase takes the upper pointer bits and ignores the data word.
// - Erase select clears on erase completion or when no store comes in four cycles.
// - Core is stalled for the whole page erase or page write.
// - Enable permits a store only during the following four cycles.
// - Enable alone stores the data word at the pointer, pointer bit zero ignored.
// - Enable clears after a store completes or when four cycles pass without one.
// - Enable stays set during page erase and page write for polling.
// - Only the six legal low-bit patterns take effect on a control write.
// - EEPROM write busy blocks flash programming and fuse and lock readback.
// - Pointer one with readback armed returns lock bits on bits one and zero.
// - Readback bits clear on read, three cycles without load, or four without store.
// - With readback clear, the load instruction reads program memory normally.
// - Pointer zero with readback armed returns the whole low fuse byte.
// - Pointer three with readback armed returns the whole high fuse byte.
// - Pointer two with readback armed returns the extended fuse byte, bit zero.
// - Programmed bits read zero, unprogrammed bits read one.
// - Lock bits return to one only through chip erase; reset also loads them to one here.
`include "spc_defs.svh"

module spc_self_program #(
  parameter int PAGE_LSB = 6
) (
  input  wire logic                         clk_in,
  input  wire logic                         nrst_in,
  input  wire logic                         ce_in,
  input  wire logic [7:0]                   s_axi_awaddr_in,
  input  wire logic                         s_axi_awvalid_in,
  output logic                              s_axi_awready_out,
  input  wire logic [31:0]                  s_axi_wdata_in,
  input  wire logic [3:0]                   s_axi_wstrb_in,
  input  wire logic                         s_axi_wvalid_in,
  output logic                              s_axi_wready_out,
  output logic [1:0]                        s_axi_bresp_out,
  output logic                              s_axi_bvalid_out,
  input  wire logic                         s_axi_bready_in,
  input  wire logic [7:0]                   s_axi_araddr_in,
  input  wire logic                         s_axi_arvalid_in,
  output logic                              s_axi_arready_out,
  output logic [31:0]                       s_axi_rdata_out,
  output logic [1:0]                        s_axi_rresp_out,
  output logic                              s_axi_rvalid_out,
  input  wire logic                         s_axi_rready_in,
  input  wire spc_pkg::spc_core_req_type    core_req_in,
  output logic                              core_stall_out,
  output logic                              load_override_out,
  output logic [7:0]                        load_data_out,
  input  wire logic                         eeprom_write_busy_in,
  output logic                              flash_req_out,
  output spc_pkg::spc_op_type               flash_op_out,
  output logic [15:0]                       flash_addr_out,
  output logic [15:0]                       flash_data_out,
  input  wire logic                         flash_done_in,
  input  wire logic [7:0]                   fuse_low_byte_in,
  input  wire logic [7:0]                   fuse_high_byte_in,
  input  wire logic                         fuse_extended_byte_in,
  input  wire logic                         chip_erase_in,
  input  wire logic                         lock_program_in,
  input  wire logic [1:0]                   lock_value_in
);
  import spc_pkg::*;

  localparam logic [15:0] PAGE_MASK = 16'((32'h1 << PAGE_LSB) - 32'h1);

  spc_state_type s_q;
  spc_state_type s_d;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic legal_pattern(input logic [5:0] pat);
    legal_pattern = (pat == `SPC_PAT_SIG_READ) || (pat == `SPC_PAT_CLR_BUF) ||
                    (pat == `SPC_PAT_FUSE_READ) || (pat == `SPC_PAT_PG_WRITE) ||
                    (pat == `SPC_PAT_PG_ERASE) || (pat == `SPC_PAT_STORE);
  endfunction : legal_pattern

  // Raw cell values pass through: programmed reads zero
  function automatic logic [7:0] fuse_mux(input logic [15:0] ptr,
                                          input logic [1:0]  lock,
                                          input logic [7:0]  low,
                                          input logic [7:0]  high,
                                          input logic        ext);
    fuse_mux = 8'hff;
    unique case (ptr)
      `SPC_PTR_FUSE_LOW:  fuse_mux = low;
      `SPC_PTR_LOCK:      fuse_mux = {6'h3f, lock};
      `SPC_PTR_FUSE_EXT:  fuse_mux = {7'h7f, ext};
      `SPC_PTR_FUSE_HIGH: fuse_mux = high;
      default:            fuse_mux = 8'hff;
    endcase
  endfunction : fuse_mux

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       wr_fire;
    logic [5:0] pat;
    wr_fire = 1'b0;
    pat     = 6'h00;
    s_d            = s_q;
    s_d.flash_req  = 1'b0;
    s_d.load_valid = 1'b0;

    // Lock cells: program clears bits, chip erase and reset set them
    if (chip_erase_in) begin
      s_d.lock = `SPC_LOCK_RESET;
    end else if (lock_program_in) begin
      s_d.lock = s_q.lock & lock_value_in;
    end

    unique case (s_q.fsm)
      SPC_IDLE: begin
      end
      SPC_ARMED: begin
        if (s_q.store_win != 3'h0) begin
          s_d.store_win = s_q.store_win - 3'h1;
        end
        if (s_q.load_win != 2'h0) begin
          s_d.load_win = s_q.load_win - 2'h1;
        end
        if (core_req_in.store && !eeprom_write_busy_in) begin
          s_d.flash_addr = core_req_in.pointer & ~16'h0001;
          s_d.flash_data = core_req_in.data_word;
          s_d.store_win  = 3'h0;
          s_d.load_win   = 2'h0;
          if (s_q.ctrl[`SPC_BIT_PG_ERASE]) begin
            s_d.flash_req  = 1'b1;
            s_d.flash_op   = SPC_OP_ERASE;
            s_d.flash_addr = core_req_in.pointer & ~PAGE_MASK;
            s_d.flash_data = 16'h0000;
            s_d.stall      = 1'b1;
            s_d.fsm        = SPC_BUSY;
          end else if (s_q.ctrl[`SPC_BIT_PG_WRITE]) begin
            s_d.flash_req  = 1'b1;
            s_d.flash_op   = SPC_OP_WRITE;
            s_d.flash_addr = core_req_in.pointer & ~PAGE_MASK;
            s_d.stall      = 1'b1;
            s_d.fsm        = SPC_BUSY;
          end else begin
            s_d.flash_req = !(s_q.ctrl[`SPC_BIT_FUSE_READ] ||
                              s_q.ctrl[`SPC_BIT_SIG_READ]);
            s_d.flash_op  = s_q.ctrl[`SPC_BIT_CLR_BUF] ? SPC_OP_CLEAR
                                                       : SPC_OP_STORE;
            s_d.ctrl      = 6'h00;
            s_d.fsm       = SPC_IDLE;
          end
        end else if (core_req_in.load && s_q.ctrl[`SPC_BIT_FUSE_READ] &&
                     !eeprom_write_busy_in) begin
          s_d.load_valid = 1'b1;
          s_d.load_data  = fuse_mux(core_req_in.pointer, s_q.lock,
                                    fuse_low_byte_in, fuse_high_byte_in,
                                    fuse_extended_byte_in);
          s_d.ctrl       = 6'h00;
          s_d.store_win  = 3'h0;
          s_d.load_win   = 2'h0;
          s_d.fsm        = SPC_IDLE;
        end else if ((s_q.store_win == 3'h1) ||
                     (s_q.ctrl[`SPC_BIT_FUSE_READ] && s_q.load_win == 2'h1)) begin
          s_d.ctrl      = 6'h00;
          s_d.store_win = 3'h0;
          s_d.load_win  = 2'h0;
          s_d.fsm       = SPC_IDLE;
        end
      end
      SPC_BUSY: begin
        if (flash_done_in) begin
          s_d.ctrl  = 6'h00;
          s_d.stall = 1'b0;
          s_d.fsm   = SPC_IDLE;
        end
      end
      default: begin
        s_d.fsm = SPC_IDLE;
      end
    endcase

    // ---------------------------------------------------------------
    // AXI4-Lite write path
    // ---------------------------------------------------------------
    if (s_q.bvalid && s_axi_bready_in) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.awready && s_axi_awvalid_in) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr_in;
    end
    if (s_q.wready && s_axi_wvalid_in) begin
      s_d.w_have  = 1'b1;
      s_d.w_data  = s_axi_wdata_in[7:0];
      s_d.w_strb0 = s_axi_wstrb_in[0];
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      wr_fire    = 1'b1;
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = ((s_q.aw_addr == `SPC_OFS_CTRL) || (s_q.aw_addr == `SPC_OFS_STATUS))
                    ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
    end
    pat = s_q.w_data[5:0];
    // Control write: ignored while busy or EEPROM write runs
    if (wr_fire && (s_q.aw_addr == `SPC_OFS_CTRL) && s_q.w_strb0 &&
        legal_pattern(pat) && !eeprom_write_busy_in &&
        (s_q.fsm != SPC_BUSY)) begin
      s_d.ctrl      = pat;
      s_d.store_win = `SPC_STORE_WINDOW;
      s_d.load_win  = pat[`SPC_BIT_FUSE_READ] ? `SPC_LOAD_WINDOW : 2'h0;
      s_d.fsm       = SPC_ARMED;
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // ---------------------------------------------------------------
    // AXI4-Lite read path
    // ---------------------------------------------------------------
    if (s_q.rvalid && s_axi_rready_in) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && s_axi_arvalid_in) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `SPC_RESP_OKAY;
      if (s_axi_araddr_in == `SPC_OFS_CTRL) begin
        s_d.rdata = {26'h0, s_q.ctrl};
      end else if (s_axi_araddr_in == `SPC_OFS_STATUS) begin
        s_d.rdata = {22'h0, s_q.lock, 5'h0, s_q.stall, eeprom_write_busy_in,
                     (s_q.fsm == SPC_BUSY)};
      end else begin
        s_d.rdata = 32'h0;
        s_d.rresp = `SPC_RESP_SLVERR;
      end
    end
    s_d.arready = !s_d.rvalid;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q          <= '0;
      s_q.fsm      <= SPC_IDLE;
      s_q.flash_op <= SPC_OP_STORE;
      s_q.lock     <= `SPC_LOCK_RESET;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_out = s_q.awready;
  assign s_axi_wready_out  = s_q.wready;
  assign s_axi_bvalid_out  = s_q.bvalid;
  assign s_axi_bresp_out   = s_q.bresp;
  assign s_axi_arready_out = s_q.arready;
  assign s_axi_rvalid_out  = s_q.rvalid;
  assign s_axi_rresp_out   = s_q.rresp;
  assign s_axi_rdata_out   = s_q.rdata;
  assign core_stall_out    = s_q.stall;
  assign load_override_out = s_q.load_valid;
  assign load_data_out     = s_q.load_data;
  assign flash_req_out     = s_q.flash_req;
  assign flash_op_out      = s_q.flash_op;
  assign flash_addr_out    = s_q.flash_addr;
  assign flash_data_out    = s_q.flash_data;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  AST_ERASE_START: assert property (ce_in && s_q.fsm == SPC_ARMED && core_req_in.store &&
      s_q.ctrl[`SPC_BIT_PG_ERASE] && !eeprom_write_busy_in
      |=> flash_req_out && flash_op_out == SPC_OP_ERASE && s_q.fsm == SPC_BUSY)
    else $error("page erase not started");
  AST_ERASE_ADDR: assert property (flash_req_out && flash_op_out == SPC_OP_ERASE
      |-> (flash_addr_out & PAGE_MASK) == 16'h0000 && flash_data_out == 16'h0000)
    else $error("erase address or data wrong");
  AST_STALL: assert property (s_q.fsm == SPC_BUSY |-> core_stall_out)
    else $error("core not stalled in flash op");
  AST_WINDOW: assert property (ce_in && s_q.fsm == SPC_IDLE && $past(ce_in) ##1
      s_q.fsm == SPC_ARMED |-> s_q.store_win == `SPC_STORE_WINDOW)
    else $error("store window not four");
  AST_EXPIRE: assert property (ce_in && s_q.fsm == SPC_ARMED && s_q.store_win == 3'h1 &&
      !core_req_in.store && !core_req_in.load |=> s_q.ctrl == 6'h00)
    else $error("enable did not clear on expiry");
  AST_HOLD_EN: assert property (s_q.fsm == SPC_BUSY |-> s_q.ctrl[`SPC_BIT_ENABLE])
    else $error("enable dropped during flash op");
  AST_LEGAL: assert property (s_q.ctrl == 6'h00 || legal_pattern(s_q.ctrl))
    else $error("illegal control pattern held");
  AST_EE_BLOCK: assert property (ce_in && eeprom_write_busy_in
      |=> !flash_req_out && !load_override_out)
    else $error("operation ran during eeprom write");
  AST_LOCK_READ: assert property (ce_in && s_q.fsm == SPC_ARMED && core_req_in.load &&
      !core_req_in.store && s_q.ctrl[`SPC_BIT_FUSE_READ] && !eeprom_write_busy_in &&
      core_req_in.pointer == `SPC_PTR_LOCK
      |=> load_override_out && load_data_out[1:0] == $past(s_q.lock))
    else $error("lock readback wrong");
  AST_READ_CLEAR: assert property (load_override_out |-> s_q.ctrl == 6'h00)
    else $error("readback bits not cleared");
  AST_NORMAL_LOAD: assert property (ce_in && !s_q.ctrl[`SPC_BIT_FUSE_READ]
      |=> !load_override_out)
    else $error("load overridden while not armed");
  AST_FUSE_LOW: assert property (ce_in && s_q.fsm == SPC_ARMED && core_req_in.load &&
      !core_req_in.store && s_q.ctrl[`SPC_BIT_FUSE_READ] && !eeprom_write_busy_in &&
      core_req_in.pointer == `SPC_PTR_FUSE_LOW |=> load_data_out == $past(fuse_low_byte_in))
    else $error("low fuse readback wrong");
  AST_LOCK_SET: assert property (ce_in && !chip_erase_in
      |=> (s_q.lock & ~$past(s_q.lock)) == 2'h0)
    else $error("lock bit erased without chip erase");

  COV_ERASE: cover property (flash_req_out && flash_op_out == SPC_OP_ERASE);
  COV_STORE: cover property (flash_req_out && flash_op_out == SPC_OP_STORE);
  COV_LOCK:  cover property (load_override_out);
  COV_DONE:  cover property (s_q.fsm == SPC_BUSY ##1 s_q.fsm == SPC_IDLE);

endmodule : spc_self_program

/* File: verif/spc_core_model.sv */
/*
  Core and flash stand-in for the self-programming block: issues store and
  load strobes, answers page erase and page write with a done pulse after a
  settable delay, and logs every flash request and readback override.
  Assumes one clock shared with the block under test.
*/
module spc_core_model (
  input  wire logic                 clk_in,
  input  wire logic                 flash_req_in,
  input  wire spc_pkg::spc_op_type  flash_op_in,
  input  wire logic [15:0]          flash_addr_in,
  input  wire logic [15:0]          flash_data_in,
  input  wire logic                 override_in,
  input  wire logic [7:0]           load_data_in,
  output spc_pkg::spc_core_req_type core_req_out,
  output logic                      flash_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  int          req_cnt = 0;
  int          ovr_cnt = 0;
  int          done_delay = 6;
  int          left = 0;
  spc_op_type  last_op;
  logic [15:0] last_addr;
  logic [15:0] last_data;
  logic [7:0]  last_load;

  initial begin
    core_req_out = '0;
    flash_done_out = 1'b0;
  end

  // ---------------------------------------------------------------
  // Flash side: done only for erase and page write
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    flash_done_out <= (left == 1);
    if (left != 0) left = left - 1;
    if (flash_req_in) begin
      req_cnt++;
      last_op = flash_op_in;
      last_addr = flash_addr_in;
      last_data = flash_data_in;
      if (flash_op_in inside {SPC_OP_ERASE, SPC_OP_WRITE}) left = done_delay;
    end
    if (override_in) begin
      ovr_cnt++;
      last_load = load_data_in;
    end
  end

  // ---------------------------------------------------------------
  // Core side: one instruction at a time, data lines scrambled after
  // ---------------------------------------------------------------
  task automatic issue(input logic st, input logic [15:0] ptr, input logic [15:0] dw);
    core_req_out <= '{store: st, load: !st, pointer: ptr, data_word: dw};
    @(posedge clk_in);
    core_req_out <= '{store: 1'b0, load: 1'b0, pointer: ~ptr, data_word: ~dw};
  endtask : issue
endmodule : spc_core_model

/* File: verif/testbench.sv */
/*
  Self-checking bench for the self-programming block: AXI4-Lite master
  tasks, one task per scenario, core and flash partner model.
  Assumes the design package and the partner model are compiled first.
*/
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  logic clk_in = 0, nrst_in = 0, ce_in = 1, s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
  logic s_axi_bready_in = 0, s_axi_arvalid_in = 0, eeprom_write_busy_in = 0, s_axi_rready_in = 0;
  logic chip_erase_in = 0, lock_program_in = 0, fuse_extended_byte_in = 0;
  logic [7:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic [7:0] fuse_low_byte_in = 8'h5a, fuse_high_byte_in = 8'hc3;
  logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in = '0;
  logic [1:0] lock_value_in = 2'h3, s_axi_bresp_out, s_axi_rresp_out;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, core_stall_out, load_override_out, flash_req_out, flash_done_in;
  logic [7:0] load_data_out;
  logic [15:0] flash_addr_out, flash_data_out;
  spc_core_req_type core_req_in;
  spc_op_type flash_op_out;
  int failures = 0, samples_checked = 0, cycles = 0;

  always #4 clk_in = ~clk_in;

  spc_self_program #(.PAGE_LSB(6)) dut (.clk_in, .nrst_in, .ce_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rready_in,
    .s_axi_rvalid_out, .core_req_in, .core_stall_out, .load_override_out, .load_data_out,
    .eeprom_write_busy_in, .flash_req_out, .flash_op_out, .flash_addr_out, .flash_data_out,
    .flash_done_in, .fuse_low_byte_in, .fuse_high_byte_in, .fuse_extended_byte_in,
    .chip_erase_in, .lock_program_in, .lock_value_in);

  spc_core_model core (.clk_in, .flash_req_in(flash_req_out), .flash_op_in(flash_op_out),
    .flash_addr_in(flash_addr_out), .flash_data_in(flash_data_out),
    .override_in(load_override_out), .load_data_in(load_data_out),
    .core_req_out(core_req_in), .flash_done_out(flash_done_in));

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    bit ad = 0;
    bit wd = 0;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, d};
    s_axi_wstrb_in <= 4'h1;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_in);
      if (s_axi_awready_out && !ad) begin
        ad = 1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (s_axi_wready_out && !wd) begin
        wd = 1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    do @(posedge clk_in); while (!s_axi_bvalid_out);
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do @(posedge clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge clk_in); while (!s_axi_rvalid_out);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask : axi_read

  task automatic ctl(input logic [7:0] d);
    logic [1:0] r;
    axi_write(8'h00, d, r);
    `CHK(r, 2'h0)
  endtask : ctl

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_modes;
    logic [7:0] pat[6] = '{8'h01, 8'h03, 8'h05, 8'h11, 8'h09, 8'h21};
    spc_op_type op[4] = '{SPC_OP_STORE, SPC_OP_ERASE, SPC_OP_WRITE, SPC_OP_CLEAR};
    int n;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++) begin
      n = core.req_cnt;
      ctl(pat[i]);
      core.issue(1'b1, 16'h12ff, 16'hbeef);
      repeat (3) @(posedge clk_in);
      `CHK(core.req_cnt, n + (i < 4))
      if (i < 4) `CHK(core.last_op, op[i])
      if (i == 0) `CHK({core.last_addr, core.last_data}, 32'h12febeef)
      if (i == 1) `CHK({core.last_addr, core.last_data}, 32'h12c00000)
      if (i == 1 || i == 2) begin
        `CHK(core_stall_out, 1'b1)
        axi_read(8'h00, d, r);
        `CHK(d, {24'h0, pat[i]})
        repeat (core.done_delay + 3) @(posedge clk_in);
        `CHK(core_stall_out, 1'b0)
      end
    end
  endtask : t_modes

  task automatic t_expire;
    logic [7:0] pat_e[2] = '{8'h01, 8'h03};
    int n;
    for (int d = 2; d < 4; d++) begin
      foreach (pat_e[k]) begin
        n = core.req_cnt;
        ctl(pat_e[k]);
        repeat (d) @(posedge clk_in);
        core.issue(1'b1, 16'h0400, 16'h1234);
        repeat (core.done_delay + 6) @(posedge clk_in);
        `CHK(core.req_cnt, n + (d == 2))
      end
    end
  endtask : t_expire

  // Window counts only enabled cycles: store on the last live edge
  task automatic t_enable;
    int n = core.req_cnt;
    ctl(8'h01);
    ce_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    ce_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    core.issue(1'b1, 16'h0200, 16'h0042);
    repeat (3) @(posedge clk_in);
    `CHK(core.req_cnt, n + 1)
  endtask : t_enable

  task automatic t_busy;
    int n = core.req_cnt;
    int m = core.ovr_cnt;
    eeprom_write_busy_in <= 1'b1;
    ctl(8'h09);
    core.issue(1'b0, 16'h0000, 16'h0000);
    eeprom_write_busy_in <= 1'b0;
    ctl(8'h01);
    eeprom_write_busy_in <= 1'b1;
    core.issue(1'b1, 16'h0010, 16'h5555);
    repeat (3) @(posedge clk_in);
    `CHK(core.req_cnt, n)
    `CHK(core.ovr_cnt, m)
    eeprom_write_busy_in <= 1'b0;
  endtask : t_busy

  task automatic t_readback;
    logic [7:0] exp[4] = '{8'h5a, 8'hfe, 8'hfe, 8'hc3};
    int n;
    lock_program_in <= 1'b1;
    lock_value_in <= 2'h2;
    @(posedge clk_in);
    lock_program_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (i == 4) chip_erase_in <= 1'b1;
      n = core.ovr_cnt;
      ctl(8'h09);
      chip_erase_in <= 1'b0;
      core.issue(1'b0, (i == 4) ? 16'h0001 : 16'(i), 16'h0);
      repeat (3) @(posedge clk_in);
      `CHK(core.ovr_cnt, n + 1)
      `CHK(core.last_load, (i == 4) ? 8'hff : exp[i])
    end
    ctl(8'h09);
    repeat (2) @(posedge clk_in);
    core.issue(1'b0, 16'h0001, 16'h0);
    repeat (3) @(posedge clk_in);
    `CHK(core.ovr_cnt, n + 1)
  endtask : t_readback

  task automatic t_bus;
    logic [1:0] r;
    logic [31:0] d;
    axi_write(8'h40, 8'h01, r);
    `CHK(r, 2'h2)
    axi_read(8'h00, d, r);
    `CHK(d, 32'h0)
    `CHK(r, 2'h0)
    axi_read(8'h04, d, r);
    `CHK(d, 32'h300)
  endtask : t_bus

  // ---------------------------------------------------------------
  // Sequence, timeout and verdict
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    t_modes();
    t_expire();
    t_enable();
    t_busy();
    t_readback();
    t_bus();
    stop_test();
  end
endmodule : testbench
